/* hw/move_exec_pkg.sv */
// constants and types for the literal and indirect move execution block
package move_exec_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_INSTR = 8'h00;
  localparam logic [7:0] REG_ACC = 8'h04;
  localparam logic [7:0] REG_BANK = 8'h08;
  localparam logic [7:0] REG_PAGE = 8'h0c;
  localparam logic [7:0] REG_OPTION = 8'h10;
  localparam logic [7:0] REG_PTR0 = 8'h14;
  localparam logic [7:0] REG_PTR1 = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1c;
  localparam logic [7:0] REG_POWER_CONTROL_REGISTER = 8'h20;
  localparam logic [7:0] REG_PC = 8'h24;
  localparam logic [7:0] REG_MEMSEL = 8'h28;
  localparam logic [7:0] REG_MEMDATA = 8'h2c;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_OPTION = 8'hff;
  localparam logic RST_FLAG_N = 1'h1;
  // ----------------------------------------------------------------
  // instruction encodings and fields
  // ----------------------------------------------------------------
  localparam logic [13:0] OPC_NOP = 14'h0000;
  localparam logic [13:0] OPC_RESET = 14'h0001;
  localparam logic [13:0] OPC_OPTION = 14'h0062;
  localparam logic [8:0] PAT_BANK = 9'h001;
  localparam logic [10:0] PAT_IND = 11'h003;
  localparam logic [6:0] PAT_REL = 7'h7f;
  localparam logic [6:0] PAT_PAGE = 7'h63;
  localparam logic [5:0] PAT_ACC = 6'h30;
  localparam logic [6:0] PAT_DIRECT = 7'h01;
  localparam int IND_SEL_BIT = 2;
  localparam int REL_SEL_BIT = 6;
  localparam logic [6:0] WIN0_F = 7'h00;
  localparam logic [6:0] WIN1_F = 7'h01;
  localparam logic [1:0] MM_PRE_INC = 2'h0;
  localparam logic [1:0] MM_PRE_DEC = 2'h1;
  localparam logic [1:0] MM_POST_INC = 2'h2;
  localparam logic [1:0] MM_POST_DEC = 2'h3;
  // ----------------------------------------------------------------
  // decoded operation
  // ----------------------------------------------------------------
  typedef enum logic [9:0] {
    OP_NONE = 10'h001,
    OP_NOP = 10'h002,
    OP_RESET = 10'h004,
    OP_OPTION = 10'h008,
    OP_BANK = 10'h010,
    OP_PAGE = 10'h020,
    OP_ACC = 10'h040,
    OP_DIRECT = 10'h080,
    OP_IND = 10'h100,
    OP_REL = 10'h200
  } op_t;
endpackage : move_exec_pkg

/* hw/move_exec.sv */
// execution unit for literal loads, accumulator stores, nop and soft reset
`timescale 1ns/1ns
`default_nettype none
// Function
// - the bank literal load puts its 5-bit operand in the bank select register, flags untouched.
// - the page literal load puts its 7-bit operand in the pc high latch, flags untouched.
// - the accumulator literal load copies its 8-bit operand in one word and one cycle.
// - the direct store writes the accumulator to a 7-bit addressed file register.
// - the indirect store writes the accumulator where one of two 16-bit pointers points.
// - code 00/01/10/11 selects pre-inc, pre-dec, post-inc, post-dec pointer update.
// - relative form addresses pointer plus signed 6-bit offset, pointer unchanged.
// - pointer arithmetic wraps within 16 bits both ways.
// - pointer update and indirect store change no status flag.
// - window registers have no storage and redirect to their pointer's location.
// - the option load copies the accumulator into the option register, flags untouched.
// - soft reset resets the core and clears the active-low soft reset flag.
module move_exec #(
  parameter int DEPTH = 128
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [move_exec_pkg::ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [move_exec_pkg::ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic soft_reset
);
  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] acc;
    logic [4:0] bank;
    logic [6:0] page;
    logic [7:0] option;
    logic [1:0][15:0] ptr;
    logic [2:0] status;
    logic flag_n;
    logic [14:0] pc;
    logic [13:0] instr;
    logic [DEPTH-1:0][7:0] mem;
    logic [15:0] memsel;
    logic soft_rst;
    logic awready;
    logic wready;
    logic aw_held;
    logic w_held;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t st_q;
  state_t st_d;
  logic exec;
  logic [13:0] ins;
  move_exec_pkg::op_t op;
  logic sel;
  logic [1:0] mm;
  logic [15:0] ptr_old;
  logic [15:0] ptr_new;
  logic [15:0] ea;
  logic [AW-1:0] idx;
  logic [32:0] rd_w;
  logic [32:0] rd_r;
  logic [31:0] wv;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic move_exec_pkg::op_t decode(input logic [13:0] i);
    if (i == move_exec_pkg::OPC_NOP) begin
      return move_exec_pkg::OP_NOP;
    end else if (i == move_exec_pkg::OPC_RESET) begin
      return move_exec_pkg::OP_RESET;
    end else if (i == move_exec_pkg::OPC_OPTION) begin
      return move_exec_pkg::OP_OPTION;
    end else if (i[13:5] == move_exec_pkg::PAT_BANK) begin
      return move_exec_pkg::OP_BANK;
    end else if (i[13:3] == move_exec_pkg::PAT_IND) begin
      return move_exec_pkg::OP_IND;
    end else if (i[13:7] == move_exec_pkg::PAT_REL) begin
      return move_exec_pkg::OP_REL;
    end else if (i[13:7] == move_exec_pkg::PAT_PAGE) begin
      return move_exec_pkg::OP_PAGE;
    end else if (i[13:8] == move_exec_pkg::PAT_ACC) begin
      return move_exec_pkg::OP_ACC;
    end else if (i[13:7] == move_exec_pkg::PAT_DIRECT) begin
      return move_exec_pkg::OP_DIRECT;
    end
    return move_exec_pkg::OP_NONE;
  endfunction : decode

  function automatic logic [AW-1:0] to_idx(input logic [15:0] a);
    return a[AW-1:0];
  endfunction : to_idx

  // readback: {hit, data}
  function automatic logic [32:0] rd(input state_t s, input logic [7:0] a);
    logic [32:0] r;
    r = {1'b1, 32'h0000_0000};
    case ({a[7:2], 2'b00})
      move_exec_pkg::REG_INSTR: r[13:0] = s.instr;
      move_exec_pkg::REG_ACC: r[7:0] = s.acc;
      move_exec_pkg::REG_BANK: r[4:0] = s.bank;
      move_exec_pkg::REG_PAGE: r[6:0] = s.page;
      move_exec_pkg::REG_OPTION: r[7:0] = s.option;
      move_exec_pkg::REG_PTR0: r[15:0] = s.ptr[0];
      move_exec_pkg::REG_PTR1: r[15:0] = s.ptr[1];
      move_exec_pkg::REG_STATUS: r[2:0] = s.status;
      move_exec_pkg::REG_POWER_CONTROL_REGISTER: r[0] = s.flag_n;
      move_exec_pkg::REG_PC: r[14:0] = s.pc;
      move_exec_pkg::REG_MEMSEL: r[15:0] = s.memsel;
      move_exec_pkg::REG_MEMDATA: r[7:0] = s.mem[to_idx(s.memsel)];
      default: r = 33'h0_0000_0000;
    endcase
    return r;
  endfunction : rd

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.soft_rst = 1'b0;
    rd_w = rd(st_q, st_q.awaddr);
    rd_r = rd(st_q, araddr);
    for (int b = 0; b < 4; b++) begin
      wv[b*8 +: 8] = st_q.wstrb[b] ? st_q.wdata[b*8 +: 8] : rd_w[b*8 +: 8];
    end
    exec = st_q.aw_held && st_q.w_held && !st_q.bvalid &&
           ({st_q.awaddr[7:2], 2'b00} == move_exec_pkg::REG_INSTR);
    ins = wv[13:0];
    op = decode(ins);
    mm = ins[1:0];
    sel = (op == move_exec_pkg::OP_REL) ? ins[move_exec_pkg::REL_SEL_BIT]
                                         : ins[move_exec_pkg::IND_SEL_BIT];
    ptr_old = st_q.ptr[sel];
    ptr_new = ptr_old;
    ea = ptr_old;
    if (op == move_exec_pkg::OP_IND) begin
      case (mm)
        move_exec_pkg::MM_PRE_INC: begin
          ptr_new = ptr_old + 16'h0001;
          ea = ptr_new;
        end
        move_exec_pkg::MM_PRE_DEC: begin
          ptr_new = ptr_old - 16'h0001;
          ea = ptr_new;
        end
        move_exec_pkg::MM_POST_INC: ptr_new = ptr_old + 16'h0001;
        default: ptr_new = ptr_old - 16'h0001;
      endcase
    end else if (op == move_exec_pkg::OP_REL) begin
      ea = ptr_old + {{10{ins[5]}}, ins[5:0]};
    end else if (ins[6:0] == move_exec_pkg::WIN0_F || ins[6:0] == move_exec_pkg::WIN1_F) begin
      ea = st_q.ptr[ins[0]];
    end else begin
      ea = {4'h0, st_q.bank, ins[6:0]};
    end
    idx = to_idx(ea);

    // write address and data channels
    if (awvalid && st_q.awready) begin
      st_d.awready = 1'b0;
      st_d.aw_held = 1'b1;
      st_d.awaddr = awaddr;
    end
    if (wvalid && st_q.wready) begin
      st_d.wready = 1'b0;
      st_d.w_held = 1'b1;
      st_d.wdata = wdata;
      st_d.wstrb = wstrb;
    end
    if (st_q.aw_held && st_q.w_held && !st_q.bvalid) begin
      st_d.aw_held = 1'b0;
      st_d.w_held = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = rd_w[32] ? move_exec_pkg::RESP_OKAY : move_exec_pkg::RESP_DECERR;
      case ({st_q.awaddr[7:2], 2'b00})
        move_exec_pkg::REG_ACC: st_d.acc = wv[7:0];
        move_exec_pkg::REG_PTR0: st_d.ptr[0] = wv[15:0];
        move_exec_pkg::REG_PTR1: st_d.ptr[1] = wv[15:0];
        move_exec_pkg::REG_STATUS: st_d.status = wv[2:0];
        move_exec_pkg::REG_POWER_CONTROL_REGISTER: st_d.flag_n = wv[0];
        move_exec_pkg::REG_MEMSEL: st_d.memsel = wv[15:0];
        default: st_d.bresp = st_d.bresp;
      endcase
    end
    if (st_q.bvalid && bready) begin
      st_d.bvalid = 1'b0;
      st_d.awready = 1'b1;
      st_d.wready = 1'b1;
    end

    // instruction execution, status written here only by soft reset
    if (exec) begin
      st_d.instr = ins;
      st_d.pc = st_q.pc + 15'h0001;
      case (op)
        move_exec_pkg::OP_NOP: st_d.pc = st_q.pc + 15'h0001;
        move_exec_pkg::OP_BANK: st_d.bank = ins[4:0];
        move_exec_pkg::OP_PAGE: st_d.page = ins[6:0];
        move_exec_pkg::OP_ACC: st_d.acc = ins[7:0];
        move_exec_pkg::OP_OPTION: st_d.option = st_q.acc;
        move_exec_pkg::OP_DIRECT: st_d.mem[idx] = st_q.acc;
        move_exec_pkg::OP_IND: begin
          st_d.mem[idx] = st_q.acc;
          st_d.ptr[sel] = ptr_new;
        end
        move_exec_pkg::OP_REL: st_d.mem[idx] = st_q.acc;
        move_exec_pkg::OP_RESET: begin
          st_d.acc = 8'h00;
          st_d.bank = 5'h00;
          st_d.page = 7'h00;
          st_d.option = move_exec_pkg::RST_OPTION;
          st_d.ptr = '0;
          st_d.status = 3'h0;
          st_d.pc = 15'h0000;
          st_d.memsel = 16'h0000;
          st_d.flag_n = 1'b0;
          st_d.soft_rst = 1'b1;
        end
        default: st_d.pc = st_q.pc;
      endcase
    end

    // read channel
    if (arvalid && st_q.arready) begin
      st_d.arready = 1'b0;
      st_d.rvalid = 1'b1;
      st_d.rdata = rd_r[31:0];
      st_d.rresp = rd_r[32] ? move_exec_pkg::RESP_OKAY : move_exec_pkg::RESP_DECERR;
    end
    if (st_q.rvalid && rready) begin
      st_d.rvalid = 1'b0;
      st_d.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
      st_q.option <= move_exec_pkg::RST_OPTION;
      st_q.flag_n <= move_exec_pkg::RST_FLAG_N;
      st_q.awready <= 1'b1;
      st_q.wready <= 1'b1;
      st_q.arready <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign awready = st_q.awready;
  assign wready = st_q.wready;
  assign bvalid = st_q.bvalid;
  assign bresp = st_q.bresp;
  assign arready = st_q.arready;
  assign rvalid = st_q.rvalid;
  assign rdata = st_q.rdata;
  assign rresp = st_q.rresp;
  assign soft_reset = st_q.soft_rst;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_op(move_exec_pkg::op_t o);
    exec && op == o;
  endsequence
  sequence s_ind(logic [1:0] m);
    exec && op == move_exec_pkg::OP_IND && mm == m;
  endsequence

  AST_BANK: assert property (s_op(move_exec_pkg::OP_BANK) |=>
    st_q.bank == $past(ins[4:0]) && $stable(st_q.status))
    else $error("bank literal not loaded");
  AST_PAGE: assert property (s_op(move_exec_pkg::OP_PAGE) |=>
    st_q.page == $past(ins[6:0]) && $stable(st_q.status))
    else $error("page literal not loaded");
  AST_ACC: assert property (s_op(move_exec_pkg::OP_ACC) |=>
    st_q.acc == $past(ins[7:0]) && st_q.pc == $past(st_q.pc) + 15'h0001)
    else $error("accumulator literal not loaded");
  AST_DIRECT: assert property (s_op(move_exec_pkg::OP_DIRECT) |=>
    st_q.mem[$past(idx)] == $past(st_q.acc) && $stable(st_q.acc))
    else $error("direct store wrong");
  AST_WINDOW: assert property (exec && op == move_exec_pkg::OP_DIRECT &&
    ins[6:0] == 7'h00 |=> st_q.mem[to_idx($past(st_q.ptr[0]))] == $past(st_q.acc))
    else $error("window store not redirected");
  AST_PRE_INC: assert property (s_ind(2'h0) |=>
    st_q.ptr[$past(sel)] == $past(ptr_old) + 16'h0001 &&
    st_q.mem[to_idx($past(ptr_old) + 16'h0001)] == $past(st_q.acc))
    else $error("pre-increment store wrong");
  AST_POST_DEC: assert property (s_ind(2'h3) |=>
    st_q.ptr[$past(sel)] == $past(ptr_old) - 16'h0001 &&
    st_q.mem[to_idx($past(ptr_old))] == $past(st_q.acc))
    else $error("post-decrement store wrong");
  AST_REL: assert property (s_op(move_exec_pkg::OP_REL) |=>
    $stable(st_q.ptr) && st_q.mem[$past(idx)] == $past(st_q.acc))
    else $error("relative store moved pointer");
  AST_WRAP: assert property (exec && op == move_exec_pkg::OP_IND && mm == 2'h2 &&
    ptr_old == 16'hffff |=> st_q.ptr[$past(sel)] == 16'h0000)
    else $error("pointer did not wrap");
  AST_FLAGS: assert property (exec && op != move_exec_pkg::OP_RESET |=>
    $stable(st_q.status))
    else $error("status changed by execution");
  AST_OPTION: assert property (s_op(move_exec_pkg::OP_OPTION) |=>
    st_q.option == $past(st_q.acc))
    else $error("option not loaded");
  AST_RESET: assert property (s_op(move_exec_pkg::OP_RESET) |=>
    soft_reset && !st_q.flag_n && st_q.pc == 15'h0000 ##1 !soft_reset)
    else $error("soft reset wrong");
  AST_NOP: assert property (s_op(move_exec_pkg::OP_NOP) |=>
    st_q.pc == $past(st_q.pc) + 15'h0001 && $stable(st_q.acc) && $stable(st_q.mem))
    else $error("nop changed state");
endmodule : move_exec
`default_nettype wire

/* sim/tb_literal_and_indirect_move_exec.sv */
// self-checking testbench for the literal and indirect move execution block
`timescale 1ns/1ns
`default_nettype none
module tb_literal_and_indirect_move_exec;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic wvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, soft_reset;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int err_count = 0;
  int n_checks = 0;
  logic [1:0] last_resp;
  logic last_sr;
  logic [31:0] last_data;
  int m;
  logic [15:0] st, np, ea;
  logic [7:0] v, pa;
  logic [5:0] k6;

  move_exec uut (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .soft_reset(soft_reset)
  );

  initial begin
    forever #4 aclk = ~aclk;
  end

  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    last_resp = bresp;
    last_sr = soft_reset;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    last_data = rdata;
    last_resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(last_data, e);
  endtask : rd_chk

  task automatic ex(input logic [13:0] c);
    wr(move_exec_pkg::REG_INSTR, {18'h0, c});
  endtask : ex

  task automatic set_acc(input logic [7:0] k);
    ex({6'h30, k});
  endtask : set_acc

  task automatic mem_chk(input logic [6:0] a, input logic [7:0] e);
    wr(move_exec_pkg::REG_MEMSEL, {25'h0, a});
    rd_chk(move_exec_pkg::REG_MEMDATA, {24'h0, e});
  endtask : mem_chk

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk(move_exec_pkg::REG_OPTION, 32'hff);
    rd_chk(move_exec_pkg::REG_POWER_CONTROL_REGISTER, 32'h1);
    wr(move_exec_pkg::REG_STATUS, 32'h5);
    chk({30'h0, last_resp}, {30'h0, move_exec_pkg::RESP_OKAY});
    ex(14'h003f);
    rd_chk(move_exec_pkg::REG_BANK, 32'h1f);
    ex(14'h31ff);
    rd_chk(move_exec_pkg::REG_PAGE, 32'h7f);
    set_acc(8'hff);
    rd_chk(move_exec_pkg::REG_ACC, 32'hff);
    wr(move_exec_pkg::REG_BANK, 32'h0);
    rd_chk(move_exec_pkg::REG_BANK, 32'h1f);
    set_acc(8'h5a);
    ex(14'h0090);
    mem_chk(7'h10, 8'h5a);
    rd_chk(move_exec_pkg::REG_ACC, 32'h5a);
    for (m = 0; m < 4; m++) begin
      st = m[0] ? 16'h0000 : 16'hffff;
      pa = m[0] ? move_exec_pkg::REG_PTR1 : move_exec_pkg::REG_PTR0;
      np = m[0] ? st - 16'h1 : st + 16'h1;
      ea = m[1] ? st : np;
      v = 8'h21 + 8'(m);
      wr(pa, {16'h0, st});
      set_acc(v);
      ex({9'h0, 2'b11, m[0], m[1:0]});
      rd_chk(pa, {16'h0, np});
      mem_chk(ea[6:0], v);
    end
    wr(move_exec_pkg::REG_PTR1, 32'h40);
    for (m = 0; m < 2; m++) begin
      k6 = m[0] ? 6'h1f : 6'h20;
      ea = 16'h0040 + {{10{k6[5]}}, k6};
      v = 8'h60 + 8'(m);
      set_acc(v);
      ex({7'h7f, 1'b1, k6});
      mem_chk(ea[6:0], v);
    end
    rd_chk(move_exec_pkg::REG_PTR1, 32'h40);
    wr(move_exec_pkg::REG_PTR0, 32'h33);
    wr(move_exec_pkg::REG_PTR1, 32'h44);
    set_acc(8'ha5);
    ex(14'h0080);
    ex(14'h0081);
    mem_chk(7'h33, 8'ha5);
    mem_chk(7'h44, 8'ha5);
    rd_chk(move_exec_pkg::REG_PTR0, 32'h33);
    set_acc(8'h4f);
    ex(move_exec_pkg::OPC_OPTION);
    rd_chk(move_exec_pkg::REG_OPTION, 32'h4f);
    rd_chk(move_exec_pkg::REG_STATUS, 32'h5);
    wr(8'h30, 32'h1);
    chk({30'h0, last_resp}, {30'h0, move_exec_pkg::RESP_DECERR});
    rd_chk(8'h30, 32'h0);
    chk({30'h0, last_resp}, {30'h0, move_exec_pkg::RESP_DECERR});
    ex(move_exec_pkg::OPC_RESET);
    chk({31'h0, last_sr}, 32'h1);
    rd_chk(move_exec_pkg::REG_POWER_CONTROL_REGISTER, 32'h0);
    rd_chk(move_exec_pkg::REG_OPTION, 32'hff);
    rd_chk(move_exec_pkg::REG_ACC, 32'h0);
    mem_chk(7'h44, 8'ha5);
    ex(move_exec_pkg::OPC_NOP);
    chk({31'h0, last_sr}, 32'h0);
    rd_chk(move_exec_pkg::REG_PC, 32'h1);
    rd_chk(move_exec_pkg::REG_ACC, 32'h0);
    rd_chk(move_exec_pkg::REG_STATUS, 32'h0);
    summarize();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    summarize();
  end
endmodule : tb_literal_and_indirect_move_exec
`default_nettype wire
